// file: logic/eivm_ctrl.sv
// External interrupt detection, request flags and vector selection.
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "eivm_consts.svh"

module eivm_ctrl
  import eivm_pkg::*;
#(
  parameter int PC_LOW_W  = 8,
  parameter int PC_HIGH_W = 4
) (
  input  wire logic                            mclk,
  input  wire logic                            rst_b,
  input  wire eivm_pkg::eivm_addr_t            reg_addr,
  input  wire eivm_pkg::eivm_byte_t            reg_wdata,
  input  wire logic                            reg_wr,
  input  wire logic                            reg_rd,
  output eivm_pkg::eivm_byte_t                 reg_rdata,
  input  wire logic                            ext_irq_pin,
  input  wire logic [PC_LOW_W+PC_HIGH_W-1:0]   pin_change_inputs,
  input  wire logic                            io_clk_active,
  input  wire logic                            global_irq_en,
  input  wire logic [`EIVM_CAUSE_N-1:0]        reset_cause,
  input  wire logic [`EIVM_PERIPH_N-1:0]       periph_req,
  input  wire logic                            irq_ack,
  input  wire eivm_pkg::eivm_vec_t             irq_ack_vector,
  output logic                                 irq_req,
  output eivm_pkg::eivm_vec_t                  irq_vector,
  output logic                                 wake_req,
  output logic                                 pin_change_group_low_req,
  output logic                                 pin_change_group_high_req
);
  import eivm_pkg::*;

  localparam int PC_N = PC_LOW_W + PC_HIGH_W;
  localparam int VEC_N = `EIVM_VEC_N;
  localparam logic [7:0] PCM_LO_RW = 8'((1 << PC_LOW_W) - 1);
  localparam logic [7:0] PCM_HI_RW = 8'((1 << PC_HIGH_W) - 1);

  if (PC_LOW_W < 1 || PC_LOW_W > 8 || PC_HIGH_W < 1 || PC_HIGH_W > 8)
  begin : g_bad_width
    $error("eivm_ctrl: each pin-change group must hold 1 to 8 inputs");
  end

  // Registers.
  eivm_byte_t        ctrl;
  eivm_byte_t        irq_mask;
  eivm_byte_t        pcm_lo;
  eivm_byte_t        pcm_hi;
  logic              ext_flag;
  logic              pcl_flag;
  logic              pch_flag;
  logic              reset_pend;

  // Sampled pins and previous samples.
  logic [PC_N:0]     pin_sync;
  logic              ext_s;
  logic              ext_p;
  logic [PC_N-1:0]   pc_s;
  logic [PC_N-1:0]   pc_p;
  logic [1:0]        warm_cnt;
  logic              warm;

  // Decoded events.
  eivm_sense_e       sense;
  logic              level_mode;
  logic              ext_rise;
  logic              ext_fall;
  logic              ext_event;
  logic              ext_low;
  logic [PC_N-1:0]   pc_tog;
  logic              pcl_hit;
  logic              pch_hit;
  logic              wr_ctrl;
  logic              wr_mask;
  logic              wr_flags;
  logic              wr_pcm_lo;
  logic              wr_pcm_hi;
  logic              ext_clr;
  logic              pcl_clr;
  logic              pch_clr;
  logic [VEC_N-1:0]  pend;
  logic              next_req;
  eivm_vec_t         next_vec;
  eivm_byte_t        next_rdata;
  logic              ext_en;
  logic              pcl_en;
  logic              pch_en;

  eivm_sync #(
    .W (PC_N + 1)
  ) u_sync (
    .mclk  (mclk),
    .rst_b (rst_b),
    .d     ({ext_irq_pin, pin_change_inputs}),
    .q     (pin_sync)
  );

  assign ext_s = pin_sync[PC_N];
  assign pc_s  = pin_sync[PC_N-1:0];

  // Edges are ignored until the synchroniser holds real pin samples, so a
  // pin resting high at release does not look like a fresh rising edge.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      warm_cnt <= 2'h0;
    end else if (warm_cnt != `EIVM_WARM_CYCLES) begin
      warm_cnt <= warm_cnt + 2'h1;
    end
  end

  assign warm = (warm_cnt == `EIVM_WARM_CYCLES);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ext_p <= 1'b0;
      pc_p  <= '0;
    end else begin
      ext_p <= ext_s;
      pc_p  <= pc_s;
    end
  end

  assign sense = eivm_sense_e'(ctrl[`EIVM_SENSE_MSB:`EIVM_SENSE_LSB]);
  assign level_mode = (sense == EIVM_SENSE_LOW);

  assign ext_rise = ext_s & ~ext_p;
  assign ext_fall = ~ext_s & ext_p;

  always_comb begin
    ext_event = 1'b0;
    case (sense)
      EIVM_SENSE_ANY:  ext_event = ext_rise | ext_fall;
      EIVM_SENSE_FALL: ext_event = ext_fall;
      EIVM_SENSE_RISE: ext_event = ext_rise;
      default:         ext_event = 1'b0;
    endcase
    ext_event = ext_event & io_clk_active & warm;
  end

  assign ext_low = level_mode & ~ext_s & warm;

  assign pc_tog = (pc_s ^ pc_p) & {PC_N{warm}};
  assign pcl_hit = |(pc_tog[PC_LOW_W-1:0] & pcm_lo[PC_LOW_W-1:0]);
  assign pch_hit = |(pc_tog[PC_N-1:PC_LOW_W] & pcm_hi[PC_HIGH_W-1:0]);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pin_change_group_low_req  <= 1'b0;
      pin_change_group_high_req <= 1'b0;
    end else begin
      pin_change_group_low_req  <= pcl_hit;
      pin_change_group_high_req <= pch_hit;
    end
  end

  // Register write decode.
  assign wr_ctrl   = reg_wr && (reg_addr == `EIVM_OFS_CTRL);
  assign wr_mask   = reg_wr && (reg_addr == `EIVM_OFS_MASK);
  assign wr_flags  = reg_wr && (reg_addr == `EIVM_OFS_FLAGS);
  assign wr_pcm_lo = reg_wr && (reg_addr == `EIVM_OFS_PCM_LO);
  assign wr_pcm_hi = reg_wr && (reg_addr == `EIVM_OFS_PCM_HI);

  // The upper control bits are stored for software but steer nothing here.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= `EIVM_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl <= reg_wdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irq_mask <= `EIVM_MASK_RST;
    end else if (wr_mask) begin
      irq_mask <= reg_wdata & `EIVM_MASK_RW;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pcm_lo <= `EIVM_PCM_RST;
      pcm_hi <= `EIVM_PCM_RST;
    end else begin
      if (wr_pcm_lo) begin
        pcm_lo <= reg_wdata & PCM_LO_RW;
      end
      if (wr_pcm_hi) begin
        pcm_hi <= reg_wdata & PCM_HI_RW;
      end
    end
  end

  assign ext_clr = (wr_flags && reg_wdata[`EIVM_EXT_BIT]) ||
                   (irq_ack && irq_ack_vector == `EIVM_VEC_EXT);
  assign pcl_clr = (wr_flags && reg_wdata[`EIVM_PCL_BIT]) ||
                   (irq_ack && irq_ack_vector == `EIVM_VEC_PCL);
  assign pch_clr = (wr_flags && reg_wdata[`EIVM_PCH_BIT]) ||
                   (irq_ack && irq_ack_vector == `EIVM_VEC_PCH);

  // A new event in the clearing cycle sets the flag again so it is not lost.
  // set wins over clear
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ext_flag <= 1'b0;
    end else if (level_mode) begin
      ext_flag <= 1'b0;
    end else begin
      ext_flag <= ext_event | (ext_flag & ~ext_clr);
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pcl_flag <= 1'b0;
      pch_flag <= 1'b0;
    end else begin
      pcl_flag <= pcl_hit | (pcl_flag & ~pcl_clr);
      pch_flag <= pch_hit | (pch_flag & ~pch_clr);
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reset_pend <= 1'b1;
    end else begin
      reset_pend <= (|reset_cause) |
        (reset_pend & ~(irq_ack && irq_ack_vector == `EIVM_VEC_RESET));
    end
  end

  assign ext_en = global_irq_en & irq_mask[`EIVM_EXT_BIT];
  assign pcl_en = global_irq_en & irq_mask[`EIVM_PCL_BIT];
  assign pch_en = global_irq_en & irq_mask[`EIVM_PCH_BIT];

  // Peripheral sources arrive already gated by their own enables; only the
  // global enable is applied here.
  always_comb begin
    pend = '0;
    pend[`EIVM_VEC_RESET] = reset_pend;
    pend[`EIVM_VEC_EXT] = ext_en & (level_mode ? ext_low : ext_flag);
    pend[`EIVM_VEC_PCL] = pcl_en & pcl_flag;
    pend[`EIVM_VEC_PCH] = pch_en & pch_flag;
    for (int i = 0; i < `EIVM_PERIPH_N; i++) begin
      pend[int'(`EIVM_VEC_PERIPH) + i] = global_irq_en & periph_req[i];
    end
  end

  always_comb begin
    next_req = |pend;
    next_vec = `EIVM_VEC_RESET;
    for (int i = VEC_N - 1; i >= 0; i--) begin
      if (pend[i]) begin
        next_vec = eivm_vec_t'(i);
      end
    end
  end

  // The core sees the choice one cycle late; an ack in that gap names the
  // vector it took, so only that source is cleared.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irq_req    <= 1'b0;
      irq_vector <= `EIVM_VEC_RESET;
    end else begin
      irq_req    <= next_req;
      irq_vector <= next_vec;
    end
  end

  // wake without lasting level
  // Compares raw pads with the last sample, so it works with mclk stopped.
  // A wake from a level that vanishes early yields no interrupt.
  assign wake_req =
    (pcl_en & |((pin_change_inputs[PC_LOW_W-1:0] ^ pc_p[PC_LOW_W-1:0]) &
                pcm_lo[PC_LOW_W-1:0])) |
    (pch_en & |((pin_change_inputs[PC_N-1:PC_LOW_W] ^ pc_p[PC_N-1:PC_LOW_W]) &
                pcm_hi[PC_HIGH_W-1:0])) |
    (ext_en & level_mode & ~ext_irq_pin) |
    irq_req;

  // Register read mux; unmapped offsets read zero.
  always_comb begin
    next_rdata = 8'h00;
    case (reg_addr)
      `EIVM_OFS_CTRL:   next_rdata = ctrl;
      `EIVM_OFS_MASK:   next_rdata = irq_mask;
      `EIVM_OFS_FLAGS: begin
        next_rdata[`EIVM_EXT_BIT] = ext_flag;
        next_rdata[`EIVM_PCH_BIT] = pch_flag;
        next_rdata[`EIVM_PCL_BIT] = pcl_flag;
      end
      `EIVM_OFS_PCM_LO: next_rdata = pcm_lo;
      `EIVM_OFS_PCM_HI: next_rdata = pcm_hi;
      `EIVM_OFS_STATUS: begin
        next_rdata[`EIVM_ST_REQ_BIT] = irq_req;
        next_rdata[`EIVM_ST_RST_BIT] = reset_pend;
        next_rdata[`EIVM_ST_PIN_BIT] = ext_s;
        next_rdata[`EIVM_VEC_W-1:0]  = irq_vector;
      end
      default:          next_rdata = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule

// file: logic/eivm_consts.svh
// Register offsets, field positions, reset values and vector addresses.
`ifndef EIVM_CONSTS_SVH
`define EIVM_CONSTS_SVH

`define EIVM_ADDR_W         4
`define EIVM_DATA_W         8
`define EIVM_VEC_W          5
`define EIVM_VEC_N          17
`define EIVM_PERIPH_N       13
`define EIVM_CAUSE_N        4

`define EIVM_OFS_CTRL       4'h0
`define EIVM_OFS_MASK       4'h1
`define EIVM_OFS_FLAGS      4'h2
`define EIVM_OFS_PCM_LO     4'h3
`define EIVM_OFS_PCM_HI     4'h4
`define EIVM_OFS_STATUS     4'h5

`define EIVM_CTRL_RST       8'h00
`define EIVM_MASK_RST       8'h00
`define EIVM_FLAGS_RST      8'h00
`define EIVM_PCM_RST        8'h00
`define EIVM_MASK_RW        8'h70

`define EIVM_SENSE_LSB      0
`define EIVM_SENSE_MSB      1
`define EIVM_EXT_BIT        6
`define EIVM_PCH_BIT        5
`define EIVM_PCL_BIT        4
`define EIVM_ST_REQ_BIT     7
`define EIVM_ST_RST_BIT     6
`define EIVM_ST_PIN_BIT     5

`define EIVM_VEC_RESET      5'h00
`define EIVM_VEC_EXT        5'h01
`define EIVM_VEC_PCL        5'h02
`define EIVM_VEC_PCH        5'h03
`define EIVM_VEC_PERIPH     5'h04
`define EIVM_VEC_LAST       5'h10

`define EIVM_WARM_CYCLES    2'h3

`endif

// file: logic/eivm_pkg.sv
// Types shared by the external interrupt and vector map logic.
package eivm_pkg;
  typedef logic [4:0] eivm_vec_t;
  typedef logic [7:0] eivm_byte_t;
  typedef logic [3:0] eivm_addr_t;
  // Order follows the two-bit sense field encoding 00, 01, 10, 11.
  typedef enum logic [1:0] {
    EIVM_SENSE_LOW,
    EIVM_SENSE_ANY,
    EIVM_SENSE_FALL,
    EIVM_SENSE_RISE
  } eivm_sense_e;
endpackage

// file: logic/eivm_sync.sv
// Two-stage synchroniser, one per bit.
`timescale 1ns/1ps
module eivm_sync #(
  parameter int W = 13
) (
  input  wire logic         mclk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  if (W < 1) begin : g_bad_w
    $error("eivm_sync: width must be at least 1");
  end

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        meta[i] <= 1'b0;
        q[i]    <= 1'b0;
      end else begin
        meta[i] <= d[i];
        q[i]    <= meta[i];
      end
    end
  end
endmodule

// file: testbench/eivm_chk.sv
// Concurrent checks on the ports of the interrupt controller.
`timescale 1ns/1ps
module eivm_chk
  import eivm_pkg::*;
#(
  parameter int PC_LOW_W  = 8,
  parameter int PC_HIGH_W = 4
) (
  input wire logic                          mclk,
  input wire logic                          rst_b,
  input wire eivm_pkg::eivm_addr_t          reg_addr,
  input wire logic                          reg_rd,
  input wire eivm_pkg::eivm_byte_t          reg_rdata,
  input wire logic [PC_LOW_W+PC_HIGH_W-1:0] pin_change_inputs,
  input wire logic                          global_irq_en,
  input wire logic [3:0]                    reset_cause,
  input wire logic [12:0]                   periph_req,
  input wire logic                          irq_req,
  input wire eivm_pkg::eivm_vec_t           irq_vector,
  input wire logic                          wake_req,
  input wire logic                          pin_change_group_low_req,
  input wire logic                          pin_change_group_high_req
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  logic [2:0] lo_age;
  logic [2:0] hi_age;
  // Ages saturate so that a quiet group never wraps back to a young age.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      lo_age <= 3'h7;
    end else if (pin_change_inputs[PC_LOW_W-1:0] !=
                 $past(pin_change_inputs[PC_LOW_W-1:0])) begin
      lo_age <= 3'h0;
    end else if (lo_age != 3'h7) begin
      lo_age <= lo_age + 3'h1;
    end
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hi_age <= 3'h7;
    end else if (pin_change_inputs[PC_LOW_W+PC_HIGH_W-1:PC_LOW_W] !=
                 $past(pin_change_inputs[PC_LOW_W+PC_HIGH_W-1:PC_LOW_W])) begin
      hi_age <= 3'h0;
    end else if (hi_age != 3'h7) begin
      hi_age <= hi_age + 3'h1;
    end
  end
  sequence s_held(b);
    (global_irq_en && b) [*2];
  endsequence
  a_rd_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside read cycle");
  a_mask_rsvd: assert property (reg_rd && reg_addr == 4'h1 |=>
    (reg_rdata & 8'h8F) == 8'h00) else $error("reserved mask bits set");
  a_reset_vec: assert property (reset_cause != 4'h0 |=> ##1
    irq_req && irq_vector == 5'h00) else $error("reset vector missing");
  a_ext_gate: assert property (irq_req && irq_vector == 5'h01 |->
    $past(global_irq_en)) else $error("pin vector without global enable");
  a_wake_follows: assert property (irq_req |-> wake_req)
    else $error("wake low while request pending");
  a_low_cause: assert property (pin_change_group_low_req |->
    lo_age <= 3'h5) else $error("low group request without toggle");
  a_high_cause: assert property (pin_change_group_high_req |->
    hi_age <= 3'h5) else $error("high group request without toggle");
  a_wdog_vec: assert property (s_held(periph_req[0]) |=>
    irq_req && irq_vector <= 5'h04) else $error("watchdog vector wrong");
  a_tmr_vec: assert property (s_held(periph_req[1]) |=>
    irq_req && irq_vector <= 5'h05) else $error("capture vector wrong");
  a_serial_vec: assert property (s_held(periph_req[12]) |=>
    irq_req && irq_vector <= 5'h10) else $error("serial vector wrong");
endmodule
bind eivm_ctrl eivm_chk #(
  .PC_LOW_W (PC_LOW_W),
  .PC_HIGH_W(PC_HIGH_W)
) u_chk (
  .mclk, .rst_b, .reg_addr, .reg_rd, .reg_rdata, .pin_change_inputs,
  .global_irq_en, .reset_cause, .periph_req, .irq_req, .irq_vector,
  .wake_req, .pin_change_group_low_req, .pin_change_group_high_req
);

// file: testbench/eivm_core_model.sv
// Behavioural processor core that takes offered interrupt vectors.
`timescale 1ns/1ps
module eivm_core_model
  import eivm_pkg::*;
(
  input  wire logic                mclk,
  input  wire logic                rst_b,
  input  wire logic                take,
  input  wire logic [2:0]          lat,
  input  wire logic                irq_req,
  input  wire eivm_pkg::eivm_vec_t irq_vector,
  output logic                     irq_ack,
  output eivm_pkg::eivm_vec_t      irq_ack_vector,
  output eivm_pkg::eivm_vec_t      last_vec,
  output int                       n_taken
);
  logic [2:0] wait_cnt;
  // The hold-off stops a second take of a request that is still draining.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irq_ack        <= 1'b0;
      irq_ack_vector <= 5'h00;
      last_vec       <= 5'h1F;
      n_taken        <= 0;
      wait_cnt       <= 3'h0;
    end else if (wait_cnt == 3'h0 && take && irq_req) begin
      irq_ack        <= 1'b1;
      irq_ack_vector <= irq_vector;
      last_vec       <= irq_vector;
      n_taken        <= n_taken + 1;
      wait_cnt       <= lat;
    end else begin
      irq_ack        <= 1'b0;
      irq_ack_vector <= ~irq_ack_vector;
      if (wait_cnt != 3'h0) wait_cnt <= wait_cnt - 3'h1;
    end
  end
endmodule

// file: testbench/tb.sv
// Self-checking bench for the external interrupt and vector map block.
`timescale 1ns/1ps
module tb;
  import eivm_pkg::*;
  logic       mclk, rst_b, reg_wr, reg_rd, ext_irq_pin, io_clk_active;
  logic       global_irq_en, irq_ack, irq_req, wake_req, take;
  logic       pin_change_group_low_req, pin_change_group_high_req;
  eivm_addr_t reg_addr;
  eivm_byte_t reg_wdata, reg_rdata, d, ml, mh;
  eivm_vec_t  irq_ack_vector, irq_vector, last_vec;
  logic [11:0] pin_change_inputs, t;
  logic [12:0] periph_req, pr;
  logic [3:0]  reset_cause;
  logic [2:0]  lat;
  int          n_taken, num_errors, cmp_count, nlo, nhi;
  eivm_ctrl dut (.mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .ext_irq_pin, .pin_change_inputs, .io_clk_active,
    .global_irq_en, .reset_cause, .periph_req, .irq_ack, .irq_ack_vector,
    .irq_req, .irq_vector, .wake_req, .pin_change_group_low_req,
    .pin_change_group_high_req);
  eivm_core_model core (.mclk, .rst_b, .take, .lat, .irq_req, .irq_vector,
    .irq_ack, .irq_ack_vector, .last_vec, .n_taken);
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (pin_change_group_low_req === 1'b1) nlo++;
    if (pin_change_group_high_req === 1'b1) nhi++;
  end
  task automatic ck(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input eivm_addr_t a, input eivm_byte_t v);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input eivm_addr_t a);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    // Read data stand until the next edge, so they are taken there.
    @(posedge mclk);
    d = reg_rdata;
  endtask
  // Status with the synchronised pin level masked out.
  task automatic st(input eivm_byte_t e);
    rd(4'h5);
    ck(d & 8'hDF, e);
  endtask
  task automatic wt(input int n);
    for (int k = 0; k < 40 && n_taken < n; k++) @(posedge mclk);
    if (n_taken < n) begin
      num_errors++;
      $display("ERROR %0t: core took no vector", $time);
    end
  endtask
  function automatic eivm_vec_t low_vec(input logic [12:0] r);
    low_vec = 5'h1F;
    for (int i = 12; i >= 0; i--) if (r[i]) low_vec = 5'(i + 4);
  endfunction
  // Pin flag per sense case; case 4 is any-change with the I/O clock off.
  function automatic eivm_byte_t ext_exp(input int m, input int e);
    ext_exp = ((m == 1) || (m == 2 && e == 0) || (m == 3 && e == 1)) ?
              8'h40 : 8'h00;
  endfunction
  function automatic eivm_byte_t pc_exp(input logic [11:0] tg,
      input eivm_byte_t lo, input eivm_byte_t hi);
    pc_exp = {2'b00, |(tg[11:8] & hi[3:0]), |(tg[7:0] & lo), 4'h0};
  endfunction
  task automatic summarize;
    $display("Compares %0d, errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    $display("ERROR %0t: run did not finish", $time);
    summarize;
  end
  initial begin
    {rst_b, reg_wr, reg_rd, global_irq_en, take, reg_addr} = '0;
    {reg_wdata, pin_change_inputs, periph_req, reset_cause} = '0;
    {num_errors, cmp_count, nlo, nhi} = '0;
    {ext_irq_pin, io_clk_active, lat} = {2'b11, 3'h3};
    void'($urandom(39054));
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    st(8'hC0);
    for (int a = 0; a < 5; a++) begin
      rd(4'(a));
      ck(d, 8'h00);
    end
    rd(4'hF);
    ck(d, 8'h00);
    take <= 1'b1;
    wt(1);
    take <= 1'b0;
    ck(8'(last_vec), 8'h00);
    wr(4'h1, 8'hFF);
    rd(4'h1);
    ck(d, 8'h70);
    // Case 4 is any-change with the I/O clock stopped.
    for (int m = 0; m < 5; m++) begin
      io_clk_active <= (m != 4);
      wr(4'h0, (m == 4) ? 8'h01 : 8'(m));
      for (int e = 0; e < 2; e++) begin
        wr(4'h2, 8'h40);
        ext_irq_pin <= e[0];
        repeat (6) @(posedge mclk);
        rd(4'h2);
        ck(d, ext_exp(m, e));
      end
    end
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h40);
    global_irq_en <= 1'b1;
    // hold low well past one instruction
    ext_irq_pin <= 1'b0;
    // The request is still three flops away, so the wake comes from the pad.
    @(posedge mclk);
    ck({7'h00, wake_req}, 8'h01);
    repeat (5) @(posedge mclk);
    st(8'h81);
    st(8'h81);
    rd(4'h2);
    ck(d, 8'h00);
    global_irq_en <= 1'b0;
    repeat (3) @(posedge mclk);
    st(8'h00);
    ext_irq_pin <= 1'b1;
    for (int i = 0; i < 24; i++) begin
      ml = (i == 0) ? 8'h00 : 8'($urandom);
      mh = 8'($urandom) & 8'h0F;
      t  = (i == 1) ? 12'h801 : 12'($urandom);
      wr(4'h3, ml);
      wr(4'h4, mh);
      wr(4'h2, 8'h30);
      {nlo, nhi} = '0;
      pin_change_inputs <= pin_change_inputs ^ t;
      repeat (6) @(posedge mclk);
      rd(4'h2);
      ck(d, pc_exp(t, ml, mh));
      ck(8'(nlo), {7'h00, |(t[7:0] & ml)});
      ck(8'(nhi), {7'h00, |(t[11:8] & mh[3:0])});
    end
    wr(4'h3, 8'hFF);
    wr(4'h4, 8'h0F);
    wr(4'h2, 8'h30);
    wr(4'h1, 8'h30);
    global_irq_en     <= 1'b1;
    pin_change_inputs <= ~pin_change_inputs;
    // Nothing is pending yet, so only the raw pad compare can wake.
    @(posedge mclk);
    ck({7'h00, wake_req}, 8'h01);
    repeat (3) @(posedge mclk);
    st(8'h82);
    lat  <= 3'h7;
    take <= 1'b1;
    wt(2);
    ck(8'(last_vec), 8'h02);
    wt(3);
    take <= 1'b0;
    ck(8'(last_vec), 8'h03);
    rd(4'h2);
    ck(d, 8'h00);
    for (int i = 0; i < 30; i++) begin
      pr = (i < 13) ? 13'(1 << i) : (13'($urandom) | 13'h1000);
      periph_req <= pr;
      repeat (3) @(posedge mclk);
      st({3'b100, low_vec(pr)});
    end
    periph_req    <= 13'h0000;
    global_irq_en <= 1'b0;
    lat           <= 3'h3;
    for (int c = 0; c < 4; c++) begin
      reset_cause <= 4'(1 << c);
      @(posedge mclk);
      reset_cause <= 4'h0;
      repeat (3) @(posedge mclk);
      st(8'hC0);
      take <= 1'b1;
      wt(n_taken + 1);
      take <= 1'b0;
      ck(8'(last_vec), 8'h00);
    end
    wr(4'h1, 8'h70);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    rd(4'h1);
    ck(d, 8'h00);
    st(8'hC0);
    summarize;
  end
endmodule
